// [logic/lbf_supervisor.sv]
// Added by the designer: the AHB-Lite register port and the register offsets.
`timescale 1ns/1ps
// Summary of operation
// - line below 1 V raises line-low comparator, connects 965 mV hold source.
// - comparator rising starts 50 ms blanking, no fault recorded meanwhile.
// - after blanking a 50 ms window; amplifier high in it sets fault.
// - amplifier low for whole window: no fault, normal operation.
// - interruptions under 50 ms ride through, ready output stays high.
// - fault disables both drivers, grounds soft-start node, drops ready.
// - fault detaches hold amplifier; flag holds until line recovers.
// - fault enables 7 uA hysteresis sink on sense pin.
// - settle delay after sense-path actions before drivers and ready drop.
// - before supply on, sense pin clamped low; start with fault flag high.
// - hysteresis current on in off mode only while supply is on; off whenever supply is below on.
// - skip cycles while 0.6 V lower clamp active; resume on release.
// - fold-back pin forced low during start-up unless the control register release bit is set.
// - fold-back pin grounded keeps fixed 140/105 uA oscillator currents.
// - ready high only when regulated and stable; low at start-up, off, fault.
module lbf_supervisor
   import lbf_pkg::*;
#(
   parameter int BLANK_CNT = BLANK_CYCLES,
   parameter int WINDOW_CNT = WINDOW_CYCLES,
   parameter int SETTLE_CNT = SETTLE_CYCLES
)
(
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic lineBelowRef,
   input wire logic levelHoldAmplifierHigh,
   input wire logic supplyOn,
   input wire logic otherFault,
   input wire logic regulationStable,
   input wire logic lowClampActive,
   input wire logic foldbackPinGrounded,
   output logic lineLowComparator,
   output logic holdSourceConnect,
   output logic hysteresisCurrent,
   output logic senseClampLow,
   output logic brownoutFaultFlag,
   output logic driverEnable1,
   output logic driverEnable2,
   output logic softStartGround,
   output logic supplyReadyOut,
   output logic skipCycle,
   output logic foldbackPullDown,
   output logic oscFixedCurrents
);
   lbf_state_t state_reg;
   lbf_state_t state_next;
   logic [CNT_W-1:0] count_reg;
   logic [CNT_W-1:0] count_next;
   logic fault_reg;
   logic faultOut_reg;
   logic startup_reg;
   logic supplySeen_reg;
   logic comp_reg;
   logic offMode;
   logic [31:0] ctrlWord;
   logic [31:0] statusWord;

   function automatic logic [CNT_W-1:0] lastCount(input int n);
      lastCount = CNT_W'(n - 1);
   endfunction

   lbf_ahb_slave u_bus (
      .clk_sys(clk_sys),
      .rst_b(rst_b),
      .hsel(hsel),
      .haddr(haddr),
      .htrans(htrans),
      .hwrite(hwrite),
      .hsize(hsize),
      .hwdata(hwdata),
      .hready(hready),
      .hrdata(hrdata),
      .hreadyout(hreadyout),
      .hresp(hresp),
      .statusWord(statusWord),
      .ctrlWord(ctrlWord)
   );

   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
         comp_reg <= 1'b0;
      else
         comp_reg <= lineBelowRef && supplyOn;
   end

   always_comb
   begin
      state_next = state_reg;
      count_next = count_reg + CNT_W'(1);
      unique case (state_reg)
         LBF_NORMAL:
         begin
            count_next = '0;
            if (comp_reg)
               state_next = LBF_BLANK;
         end
         LBF_BLANK:
         begin
            if (!comp_reg)
            begin
               state_next = LBF_NORMAL;
               count_next = '0;
            end
            else if (count_reg == lastCount(BLANK_CNT))
            begin
               state_next = LBF_WINDOW;
               count_next = '0;
            end
         end
         LBF_WINDOW:
         begin
            if (levelHoldAmplifierHigh)
            begin
               state_next = LBF_SETTLE;
               count_next = '0;
            end
            else if (count_reg == lastCount(WINDOW_CNT))
            begin
               state_next = LBF_NORMAL;
               count_next = '0;
            end
         end
         LBF_SETTLE:
         begin
            if (count_reg == lastCount(SETTLE_CNT))
            begin
               state_next = LBF_FAULT;
               count_next = '0;
            end
         end
         LBF_FAULT:
         begin
            count_next = '0;
            if (!lineBelowRef && supplyOn)
               state_next = LBF_NORMAL;
         end
         default:
         begin
            state_next = LBF_FAULT;
            count_next = '0;
         end
      endcase
   end

   // supply below on threshold forces the fault state
   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
      begin
         state_reg <= LBF_FAULT;
         count_reg <= '0;
      end
      else if (!supplyOn)
      begin
         state_reg <= LBF_FAULT;
         count_reg <= '0;
      end
      else
      begin
         state_reg <= state_next;
         count_reg <= count_next;
      end
   end

   // flag rises as the settle delay starts, so sense-path actions lead
   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
         fault_reg <= 1'b1;
      else
         fault_reg <= state_next == LBF_SETTLE || state_next == LBF_FAULT || !supplyOn;
   end

   // off-mode actions wait for the end of the settle delay
   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
         faultOut_reg <= 1'b1;
      else
         faultOut_reg <= state_next == LBF_FAULT || !supplyOn;
   end

   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
         supplySeen_reg <= 1'b0;
      else if (supplyOn)
         supplySeen_reg <= 1'b1;
   end

   // start-up latch: set in every off phase, cleared once regulation is stable
   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
         startup_reg <= 1'b1;
      else if (offMode)
         startup_reg <= 1'b1;
      else if (regulationStable)
         startup_reg <= 1'b0;
   end

   assign offMode = faultOut_reg || otherFault;

   // status word from the package field positions
   always_comb
   begin
      statusWord = 32'h0000_0000;
      statusWord[ST_FAULT_BIT] = brownoutFaultFlag;
      statusWord[ST_COMP_BIT] = lineLowComparator;
      statusWord[ST_HOLD_BIT] = holdSourceConnect;
      statusWord[ST_HYST_BIT] = hysteresisCurrent;
      statusWord[ST_READY_BIT] = supplyReadyOut;
      statusWord[ST_DRV_BIT] = driverEnable1;
      statusWord[ST_STATE_LSB +: $bits(lbf_state_t)] = state_reg;
   end

   assign lineLowComparator = comp_reg;
   assign brownoutFaultFlag = fault_reg;
   assign holdSourceConnect = comp_reg && !fault_reg;
   assign senseClampLow = !supplyOn;
   assign hysteresisCurrent = supplySeen_reg && supplyOn && (fault_reg || offMode);
   assign driverEnable1 = !offMode && !skipCycle;
   assign driverEnable2 = !offMode && !skipCycle;
   assign softStartGround = offMode;
   assign supplyReadyOut = !offMode && !startup_reg && regulationStable;
   assign skipCycle = lowClampActive;
   assign foldbackPullDown = (startup_reg && !ctrlWord[CTRL_FB_RELEASE_BIT]) || offMode;
   assign oscFixedCurrents = foldbackPullDown || foldbackPinGrounded;
endmodule // lbf_supervisor

// [pkg/lbf_pkg.sv]
package lbf_pkg;
   // time base
   localparam int CLK_FREQ_HZ = 250000000;
   localparam int BLANK_TIME_MS = 50;
   localparam int WINDOW_TIME_MS = 50;
   localparam int SETTLE_TIME_NS = 400;
   localparam int CLK_PERIOD_NS = 4;
   localparam int BLANK_CYCLES = CLK_FREQ_HZ / 1000 * BLANK_TIME_MS;
   localparam int WINDOW_CYCLES = CLK_FREQ_HZ / 1000 * WINDOW_TIME_MS;
   localparam int SETTLE_CYCLES = (SETTLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CNT_W = 24;
   // register map
   localparam logic [31:0] CTRL_OFFSET = 32'h0000_0000;
   localparam logic [31:0] STATUS_OFFSET = 32'h0000_0004;
   localparam int CTRL_FB_RELEASE_BIT = 0;
   localparam logic [31:0] CTRL_RESET_VALUE = 32'h0000_0000;
   localparam int ST_FAULT_BIT = 0;
   localparam int ST_COMP_BIT = 1;
   localparam int ST_HOLD_BIT = 2;
   localparam int ST_HYST_BIT = 3;
   localparam int ST_READY_BIT = 4;
   localparam int ST_DRV_BIT = 5;
   localparam int ST_STATE_LSB = 8;
   typedef enum logic [2:0] {
      LBF_NORMAL, LBF_BLANK, LBF_WINDOW, LBF_SETTLE, LBF_FAULT
   } lbf_state_t;
endpackage

// [logic/lbf_ahb_slave.sv]
`timescale 1ns/1ps
module lbf_ahb_slave
   import lbf_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic [31:0] statusWord,
   output logic [31:0] ctrlWord
);
   logic wrPend_reg;
   logic [31:0] addrPhase_reg;
   logic [31:0] ctrl_reg;
   logic [31:0] rdata_reg;
   logic take;
   logic ctrlWrite;
   logic [31:0] ctrlView;

   assign take = hsel && hready && htrans[1];
   assign ctrlWrite = wrPend_reg && addrPhase_reg[7:0] == CTRL_OFFSET[7:0];
   // a write still in its data phase is seen by a read right behind it
   assign ctrlView = ctrlWrite ? {31'h0000_0000, hwdata[CTRL_FB_RELEASE_BIT]} : ctrl_reg;
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign ctrlWord = ctrl_reg;
   assign hrdata = rdata_reg;

   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
      begin
         wrPend_reg <= 1'b0;
         addrPhase_reg <= 32'h0000_0000;
      end
      else
      begin
         wrPend_reg <= take && hwrite;
         if (take)
            addrPhase_reg <= haddr;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
         ctrl_reg <= CTRL_RESET_VALUE;
      else if (ctrlWrite)
         ctrl_reg <= ctrlView;
   end

   // read data registered at address phase, valid in the zero-wait data phase
   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
         rdata_reg <= 32'h0000_0000;
      else if (take && !hwrite)
      begin
         if (haddr[7:0] == CTRL_OFFSET[7:0])
            rdata_reg <= ctrlView;
         else if (haddr[7:0] == STATUS_OFFSET[7:0])
            rdata_reg <= statusWord;
         else
            rdata_reg <= 32'h0000_0000;
      end
   end
endmodule // lbf_ahb_slave

// [verification/lbf_supervisor_asserts.sv]
`timescale 1ns/1ps
module lbf_supervisor_asserts
#(parameter int SETTLE_CNT = 100)
(
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic lineBelowRef,
   input wire logic supplyOn,
   input wire logic lowClampActive,
   input wire logic foldbackPinGrounded,
   input wire logic lineLowComparator,
   input wire logic holdSourceConnect,
   input wire logic hysteresisCurrent,
   input wire logic senseClampLow,
   input wire logic brownoutFaultFlag,
   input wire logic driverEnable1,
   input wire logic softStartGround,
   input wire logic supplyReadyOut,
   input wire logic skipCycle,
   input wire logic oscFixedCurrents
);
   localparam int SETTLE_LIM = SETTLE_CNT + 2;
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_b);
   property p_comp; $rose(lineBelowRef) && supplyOn |=> lineLowComparator; endproperty
   a_comp: assert property (p_comp) else $error("comparator late");
   property p_blank; $rose(lineLowComparator) && !brownoutFaultFlag |-> !brownoutFaultFlag [*8]; endproperty
   a_blank: assert property (p_blank) else $error("fault in blanking");
   property p_settle; $rose(brownoutFaultFlag) && supplyReadyOut |=> supplyReadyOut; endproperty
   a_settle: assert property (p_settle) else $error("no settle delay");
   property p_off; $rose(brownoutFaultFlag) |-> ##[1:SETTLE_LIM] (!driverEnable1 && softStartGround && !supplyReadyOut); endproperty
   a_off: assert property (p_off) else $error("outputs not off");
   property p_sense;
      $rose(brownoutFaultFlag) && supplyOn |-> hysteresisCurrent && !holdSourceConnect;
   endproperty
   a_sense: assert property (p_sense) else $error("sense path wrong");
   property p_clamp; !supplyOn |-> senseClampLow && !hysteresisCurrent; endproperty
   a_clamp: assert property (p_clamp) else $error("start-up clamp");
   property p_skip; !lowClampActive |-> !skipCycle; endproperty
   a_skip: assert property (p_skip) else $error("skip stuck");
   property p_fb; foldbackPinGrounded |-> oscFixedCurrents; endproperty
   a_fb: assert property (p_fb) else $error("osc not fixed");
endmodule // lbf_supervisor_asserts
bind lbf_supervisor lbf_supervisor_asserts #(.SETTLE_CNT(SETTLE_CNT)) u_chk (.clk_sys, .rst_b,
   .lineBelowRef, .supplyOn, .lowClampActive, .foldbackPinGrounded, .lineLowComparator,
   .holdSourceConnect, .hysteresisCurrent, .senseClampLow, .brownoutFaultFlag, .driverEnable1,
   .softStartGround, .supplyReadyOut, .skipCycle, .oscFixedCurrents);

// [verification/lbf_downstream_model.sv]
`timescale 1ns/1ps
module lbf_downstream_model
(
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic supplyReadyOut,
   output logic stopped
);
   // converter latches a stop once ready drops after it ran
   logic ranReg;
   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
      begin
         ranReg <= 1'b0;
         stopped <= 1'b0;
      end
      else
      begin
         ranReg <= ranReg | supplyReadyOut;
         stopped <= stopped | (ranReg & !supplyReadyOut);
      end
   end
endmodule // lbf_downstream_model

// [verification/tb_lbf_supervisor.sv]
`timescale 1ns/1ps
module tb_lbf_supervisor;
   import lbf_pkg::*;
   localparam int BLK = 20;
   localparam int WIN = 20;
   localparam int STL = 4;
   logic clk_sys = 1'b0, rst_b = 1'b0, hsel = 1'b1, hwrite = 1'b0, lineBelowRef = 1'b0;
   logic levelHoldAmplifierHigh = 1'b0, supplyOn = 1'b0, regulationStable = 1'b0, otherFault = 1'b0;
   logic lowClampActive = 1'b0, foldbackPinGrounded = 1'b0, hreadyout, stopped, hresp;
   logic [1:0] htrans = 2'h0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
   logic lineLowComparator, holdSourceConnect, hysteresisCurrent, senseClampLow;
   logic brownoutFaultFlag, driverEnable1, driverEnable2, softStartGround, supplyReadyOut;
   logic skipCycle, foldbackPullDown, oscFixedCurrents;
   int errors = 0, nTests = 0;
   wire logic [31:0] obs = {24'h0, brownoutFaultFlag, supplyReadyOut, driverEnable1,
      driverEnable2, softStartGround, hysteresisCurrent, holdSourceConnect, lineLowComparator};
   wire logic [31:0] aux = {28'h0, senseClampLow, foldbackPullDown, skipCycle, oscFixedCurrents};
   always #2 clk_sys = ~clk_sys;
   lbf_supervisor #(.BLANK_CNT(BLK), .WINDOW_CNT(WIN), .SETTLE_CNT(STL)) dut (.clk_sys, .rst_b,
      .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata,
      .hreadyout, .hresp, .lineBelowRef, .levelHoldAmplifierHigh, .supplyOn, .otherFault,
      .regulationStable, .lowClampActive, .foldbackPinGrounded, .lineLowComparator,
      .holdSourceConnect, .hysteresisCurrent, .senseClampLow, .brownoutFaultFlag, .driverEnable1,
      .driverEnable2, .softStartGround, .supplyReadyOut, .skipCycle, .foldbackPullDown,
      .oscFixedCurrents);
   lbf_downstream_model partner (.clk_sys, .rst_b, .supplyReadyOut, .stopped);
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      nTests++;
      if (seen !== exp)
      begin
         errors++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic complete_run();
      $display("tests=%0d errors=%0d", nTests, errors);
      if (errors == 0 && nTests > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
      int n;
      @(posedge clk_sys);
      htrans <= 2'h2;
      hwrite <= wr;
      haddr <= a;
      for (int p = 0; p < 2; p++)
      begin
         n = 0;
         do
         begin
            @(posedge clk_sys);
            n++;
         end
         while (hreadyout !== 1'b1 && n < 50);
         if (hreadyout !== 1'b1)
         begin
            errors++;
            complete_run();
         end
         htrans <= 2'h0;
         hwdata <= d;
      end
      rd = hrdata;
   endtask
   task automatic line(input logic low, input logic amp, input int n);
      @(posedge clk_sys);
      lineBelowRef <= low;
      levelHoldAmplifierHigh <= amp;
      repeat (n) @(posedge clk_sys);
      @(negedge clk_sys);
   endtask
   initial
   begin
      repeat (11) @(posedge clk_sys);
      @(negedge clk_sys);
      chk(obs, 32'h88);
      chk(aux & 32'hC, 32'hC);
      @(posedge clk_sys);
      rst_b <= 1'b1;
      bus(1'b0, CTRL_OFFSET, 32'h0);
      chk(rd, CTRL_RESET_VALUE);
      chk(hresp, 32'h0);
      @(posedge clk_sys);
      supplyOn <= 1'b1;
      line(1'b0, 1'b0, 4);
      chk(obs & 32'hC0, 32'h0);
      chk(aux & 32'hC, 32'h4);
      bus(1'b1, CTRL_OFFSET, 32'h1);
      @(negedge clk_sys);
      chk(aux & 32'h4, 32'h0);
      bus(1'b1, CTRL_OFFSET, 32'h0);
      regulationStable <= 1'b1;
      line(1'b0, 1'b0, 4);
      chk(obs, 32'h70);
      $display("start-up test done");
      for (int k = 0; k < 2; k++)
      begin
         line(1'b1, 1'b1, 14);
         chk(obs, 32'h73);
         line(1'b0, 1'b0, 3);
      end
      chk(obs, 32'h70);
      chk(stopped, 32'h0);
      line(1'b1, 1'b0, BLK + WIN + 6);
      chk(obs & 32'hC0, 32'h40);
      line(1'b0, 1'b0, 3);
      $display("ride-through test done");
      line(1'b1, 1'b0, BLK + 5);
      line(1'b1, 1'b1, 2);
      chk(obs, 32'hF5);
      line(1'b1, 1'b1, STL + 3);
      chk(obs, 32'h8D);
      chk(stopped, 32'h1);
      bus(1'b0, STATUS_OFFSET, 32'h0);
      chk(rd & 32'h3F, 32'hB);
      bus(1'b0, 32'h0000_0010, 32'h0);
      chk(rd, 32'h0);
      line(1'b0, 1'b0, 10);
      chk(obs, 32'h70);
      $display("fault test done");
      @(posedge clk_sys);
      otherFault <= 1'b1;
      regulationStable <= 1'b0;
      line(1'b0, 1'b0, 2);
      chk(obs, 32'h0C);
      chk(aux & 32'h4, 32'h4);
      @(posedge clk_sys);
      otherFault <= 1'b0;
      line(1'b0, 1'b0, 3);
      chk(obs, 32'h30);
      @(posedge clk_sys);
      regulationStable <= 1'b1;
      line(1'b0, 1'b0, 3);
      chk(obs, 32'h70);
      $display("off-mode test done");
      @(posedge clk_sys);
      lowClampActive <= 1'b1;
      foldbackPinGrounded <= 1'b1;
      line(1'b0, 1'b0, 1);
      chk(aux & 32'h3, 32'h3);
      chk(obs & 32'h30, 32'h0);
      @(posedge clk_sys);
      lowClampActive <= 1'b0;
      line(1'b0, 1'b0, 1);
      chk(aux & 32'h2, 32'h0);
      chk(obs & 32'h30, 32'h30);
      $display("skip test done");
      complete_run();
   end
endmodule // tb_lbf_supervisor
